// [shared/eec_map.svh]
/*
 * Register offsets, field positions, command codes and reset values of
 * the emulated-EEPROM command controller.
 * Assumes a 32-bit APB with byte addresses on a 10-bit PADDR.
 */
`ifndef EEC_MAP_SVH
`define EEC_MAP_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define EEC_OFS_CLKDIV 10'h000
`define EEC_OFS_INDEX 10'h004
`define EEC_OFS_WORD 10'h008
`define EEC_OFS_STAT 10'h00c
`define EEC_OFS_ERRSTAT 10'h010
`define EEC_OFS_PART 10'h014
`define EEC_RAM_BASE 2'h1
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EEC_BIT_DONE 7
`define EEC_BIT_ACCERR 5
`define EEC_BIT_PVIOL 4
`define EEC_BIT_IGNORED 0
`define EEC_BIT_DIVSET 7
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define EEC_CMD_QUERY 8'h15
`define EEC_CMD_PARTITION 8'h20
`define EEC_CMD_ENABLE 8'h13
`define EEC_CMD_DISABLE 8'h14
// ----------------------------------------------------------------
// sizes and values
// ----------------------------------------------------------------
`define EEC_MAX_SECTIONS 5'h10
`define EEC_FLASH_SECTORS 8'h80
`define EEC_ONE_SEC_SECTORS 8'h0c
`define EEC_SECTORS_PER_SEC 8'h08
`define EEC_ERASED 16'hffff
`define EEC_BUF_LAST 3'h7
`endif

// [shared/eec_pkg.sv]
/*
 * Types of the emulated-EEPROM command controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package eec_pkg;
  typedef enum logic [2:0] {
    EEC_RESTORE, EEC_IDLE, EEC_EXEC, EEC_ERASE
  } eec_state_t;
  typedef struct packed {
    logic done;
    logic acc_err;
    logic prot_err;
  } eec_stat_t;
endpackage
`default_nettype wire

// [src/eec_ctrl.sv]
/*
 * Command buffer, launch, status flags, partitioning, automatic backup
 * and post-reset restore of the emulated-EEPROM region, APB slave.
 * Assumes PWR_RESETN is only asserted at power-up (it models the
 * non-volatile partition record) and that RESETN is the system reset.
 */
// Notes on behaviour
// - No partition: all RAM and flash plain, emulation off.
// - Full partition: all buffer RAM emulated, all data flash records.
// - Mixed partition: only partitioned words emulated, rest stay plain.
// - Enabled emulation copies new emulated-RAM data to record flash.
// - After reset with a partition, CPU held until records restored.
// - Emulated RAM readable by the CPU at all times, writable except while the restore or erase walk runs.
// - Index 0, command high byte, parameter low byte form word zero.
// - Further parameters go to the indexed word, up to word 7.
// - Completion flag set when command finishes; status then valid.
// - Error flags set on their condition and held until cleared.
// - Flags clear only where software writes a one.
// - Partition size in sections accepted from zero to sixteen.
// - One section needs 12 sectors, otherwise eight per section.
// - Full partition erases emulated RAM and records to 0xffff.
// - Query returns flash size in word 1, RAM size in word 2.
`default_nettype none
`include "eec_map.svh"
module eec_ctrl
  import eec_pkg::*;
#(
  parameter int SEC_WORDS = 4
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PWR_RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CPU_HOLD,
  output logic EMUL_ACTIVE
);
  localparam int WORDS = 16 * SEC_WORDS;
  localparam int AW = $clog2(WORDS);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  eec_state_t state;
  eec_stat_t stat;
  logic ignored;
  logic [6:0] flash_divider_value;
  logic div_set;
  logic [2:0] command_buffer_index;
  logic [15:0] command_buffer_word [8];
  logic [4:0] part_sec;
  logic [7:0] part_df;
  logic emul_en;
  logic [6:0] walk;
  logic [AW-1:0] scan;
  logic [15:0] ram [WORDS];
  logic [15:0] rec [WORDS];
  logic [WORDS-1:0] dirty;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_go, rd_prep, in_ram, mapped;
  logic sel_div, sel_idx, sel_word, sel_stat, sel_err, sel_part;
  logic [AW-1:0] ram_idx;
  logic [6:0] emul_words;
  logic launch_req, start, buf_wr_try, busy_ignore;
  logic walk_end, backup_go;
  logic [7:0] cmd;
  logic [7:0] req_sec;
  logic [7:0] req_df;
  logic [7:0] rec_sectors;
  logic [7:0] need_sectors;
  logic part_bad, part_ok;
  logic exec_acc, exec_pv;

  assign wr_go = PSEL & PENABLE & PREADY & PWRITE;
  assign rd_prep = PSEL & PENABLE & ~PREADY;
  assign in_ram = PADDR[9:8] == `EEC_RAM_BASE;
  assign ram_idx = PADDR[AW+1:2];
  assign sel_div = PADDR == `EEC_OFS_CLKDIV;
  assign sel_idx = PADDR == `EEC_OFS_INDEX;
  assign sel_word = PADDR == `EEC_OFS_WORD;
  assign sel_stat = PADDR == `EEC_OFS_STAT;
  assign sel_err = PADDR == `EEC_OFS_ERRSTAT;
  assign sel_part = PADDR == `EEC_OFS_PART;
  assign mapped = in_ram | sel_div | sel_idx | sel_word | sel_stat |
                  sel_err | sel_part;
  assign emul_words = 7'(part_sec * SEC_WORDS);

  assign launch_req = wr_go & sel_stat & PWDATA[`EEC_BIT_DONE];
  assign start = launch_req & stat.done & div_set;
  assign buf_wr_try = wr_go & (sel_idx | sel_word);
  assign busy_ignore = ~stat.done & (buf_wr_try | launch_req);
  assign walk_end = walk >= emul_words;
  assign backup_go = state == EEC_IDLE && emul_en &&
                     7'(scan) < emul_words && dirty[scan];

  assign cmd = command_buffer_word[0][15:8];
  assign req_df = command_buffer_word[1][7:0];
  assign req_sec = command_buffer_word[2][7:0];
  assign rec_sectors = `EEC_FLASH_SECTORS - req_df;
  always_comb begin
    need_sectors = 8'h00;
    if (req_sec == 8'h01) begin
      need_sectors = `EEC_ONE_SEC_SECTORS;
    end else if (req_sec <= 8'(`EEC_MAX_SECTIONS)) begin
      need_sectors = 8'(req_sec * `EEC_SECTORS_PER_SEC);
    end
  end
  assign part_bad = req_sec > 8'(`EEC_MAX_SECTIONS) ||
                    req_df > `EEC_FLASH_SECTORS ||
                    rec_sectors < need_sectors;
  assign part_ok = state == EEC_EXEC && cmd == `EEC_CMD_PARTITION &&
                   !emul_en && !part_bad;
  always_comb begin
    exec_acc = 1'b0;
    exec_pv = 1'b0;
    if (state == EEC_EXEC) begin
      case (cmd)
        `EEC_CMD_PARTITION: begin
          exec_pv = emul_en;
          exec_acc = !emul_en & part_bad;
        end
        `EEC_CMD_ENABLE: exec_acc = part_sec == 5'h00;
        `EEC_CMD_QUERY, `EEC_CMD_DISABLE: exec_acc = 1'b0;
        default: exec_acc = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= EEC_RESTORE;
    end else begin
      case (state)
        EEC_RESTORE: if (walk_end) state <= EEC_IDLE;
        EEC_IDLE: if (start) state <= EEC_EXEC;
        EEC_EXEC: state <= part_ok ? EEC_ERASE : EEC_IDLE;
        EEC_ERASE: if (walk_end) state <= EEC_IDLE;
        default: state <= EEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      walk <= 7'h00;
    end else if ((state == EEC_RESTORE || state == EEC_ERASE) &&
                 !walk_end) begin
      walk <= walk + 7'h01;
    end else begin
      walk <= 7'h00;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      CPU_HOLD <= 1'b1;
    end else if (state == EEC_RESTORE && walk_end) begin
      CPU_HOLD <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status flags; a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stat <= '0;
    end else begin
      if ((state == EEC_RESTORE || state == EEC_ERASE) && walk_end) begin
        stat.done <= 1'b1;
      end else if (state == EEC_EXEC && !part_ok) begin
        stat.done <= 1'b1;
      end else if (start) begin
        stat.done <= 1'b0;
      end
      if (exec_acc || (launch_req && stat.done && !div_set)) begin
        stat.acc_err <= 1'b1;
      end else if (wr_go && sel_stat && PWDATA[`EEC_BIT_ACCERR]) begin
        stat.acc_err <= 1'b0;
      end
      if (exec_pv) begin
        stat.prot_err <= 1'b1;
      end else if (wr_go && sel_stat && PWDATA[`EEC_BIT_PVIOL]) begin
        stat.prot_err <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ignored <= 1'b0;
    end else if (busy_ignore) begin
      ignored <= 1'b1;
    end else if (wr_go && sel_err && PWDATA[`EEC_BIT_IGNORED]) begin
      ignored <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clock divider, index and command buffer
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      flash_divider_value <= 7'h00;
      div_set <= 1'b0;
    end else if (wr_go && sel_div && PSTRB[0] && stat.done) begin
      flash_divider_value <= PWDATA[6:0];
      div_set <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      command_buffer_index <= 3'h0;
    end else if (wr_go && sel_idx && stat.done && PSTRB[0]) begin
      command_buffer_index <= PWDATA[2:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < 8; i++) command_buffer_word[i] <= 16'h0000;
    end else if (state == EEC_EXEC && cmd == `EEC_CMD_QUERY) begin
      command_buffer_word[1] <= {8'h00, part_df};
      command_buffer_word[2] <= {11'h000, part_sec};
    end else if (wr_go && sel_word && stat.done) begin
      if (PSTRB[1]) command_buffer_word[command_buffer_index][15:8] <=
          PWDATA[15:8];
      if (PSTRB[0]) command_buffer_word[command_buffer_index][7:0] <=
          PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // partition record and emulation enable
  // ----------------------------------------------------------------
  // partition survives system reset, as the flash record would
  always_ff @(posedge CORE_CLK or negedge PWR_RESETN) begin
    if (!PWR_RESETN) begin
      part_sec <= 5'h00;
      part_df <= `EEC_FLASH_SECTORS;
    end else if (part_ok) begin
      part_sec <= req_sec[4:0];
      part_df <= req_df;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      emul_en <= 1'b0;
      EMUL_ACTIVE <= 1'b0;
    end else if (state == EEC_EXEC && !exec_acc) begin
      if (cmd == `EEC_CMD_ENABLE) begin
        emul_en <= 1'b1;
        EMUL_ACTIVE <= 1'b1;
      end else if (cmd == `EEC_CMD_DISABLE) begin
        emul_en <= 1'b0;
        EMUL_ACTIVE <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // buffer RAM, record flash and backup tracking
  // ----------------------------------------------------------------
  // the walker wins over any CPU store made while it runs; only a few
  // cycles after reset or a partition are exposed to this
  always_ff @(posedge CORE_CLK) begin
    if (state == EEC_RESTORE && !walk_end) begin
      ram[walk[AW-1:0]] <= rec[walk[AW-1:0]];
    end else if (state == EEC_ERASE && !walk_end) begin
      ram[walk[AW-1:0]] <= `EEC_ERASED;
    end else if (wr_go && in_ram) begin
      if (PSTRB[1]) ram[ram_idx][15:8] <= PWDATA[15:8];
      if (PSTRB[0]) ram[ram_idx][7:0] <= PWDATA[7:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (state == EEC_ERASE && !walk_end) begin
      rec[walk[AW-1:0]] <= `EEC_ERASED;
    end else if (backup_go) begin
      rec[scan] <= ram[scan];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dirty <= '0;
    end else begin
      if (state == EEC_ERASE) begin
        dirty <= '0;
      end else if (backup_go) begin
        dirty[scan] <= 1'b0;
      end
      // a store in the copy cycle keeps the word pending
      if (wr_go && in_ram && 7'(ram_idx) < emul_words &&
          state != EEC_ERASE) begin
        dirty[ram_idx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      scan <= '0;
    end else if (7'(scan) + 7'h01 >= emul_words) begin
      scan <= '0;
    end else begin
      scan <= scan + AW'(1);
    end
  end

  // ----------------------------------------------------------------
  // APB answer, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= rd_prep;
      PSLVERR <= rd_prep & ~mapped;
      if (rd_prep && !PWRITE) begin
        PRDATA <= 32'h00000000;
        if (in_ram) PRDATA <= {16'h0000, ram[ram_idx]};
        if (sel_div) PRDATA <= {24'h000000, div_set, flash_divider_value};
        if (sel_idx) PRDATA <= {29'h00000000, command_buffer_index};
        if (sel_word) PRDATA <= {16'h0000,
                                 command_buffer_word[command_buffer_index]};
        if (sel_stat) PRDATA <= {24'h000000, stat.done, 1'b0,
                                 stat.acc_err, stat.prot_err, 4'h0};
        if (sel_err) PRDATA <= {31'h00000000, ignored};
        if (sel_part) PRDATA <= {16'h0000, emul_en, 2'b00, part_sec,
                                 part_df};
      end
    end
  end
endmodule
`default_nettype wire

// [tb/eec_ctrl_chk.sv]
/*
 * Port assertions for the emulated-EEPROM command controller.
 * Assumes it is bound to eec_ctrl and runs on its single clock.
 */
`default_nettype none
`include "eec_map.svh"
module eec_ctrl_chk #(
  parameter int SEC_WORDS = 4
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PWR_RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [9:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CPU_HOLD,
  input wire logic EMUL_ACTIVE
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // register words below the buffer RAM answer only at aligned offsets
  wire logic unmapped = (PADDR >= 10'h018 && PADDR < 10'h100) ||
    (PADDR < 10'h018 && PADDR[1:0] != 2'h0) || PADDR >= 10'h200;
  wire logic rd_ok = PREADY && !PWRITE;
  access_wait_a: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  err_pair_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  bus_quiet_a: assert property (!PSEL |=> !PREADY)
    else $error("ready without select");
  map_err_a: assert property (PREADY |-> PSLVERR == unmapped)
    else $error("error response does not match address map");
  restore_bound_a: assert property (
    $rose(RESETN) |-> ##[0:80] !CPU_HOLD)
    else $error("cpu hold outlasts restore");
  hold_quiet_a: assert property (CPU_HOLD |-> !EMUL_ACTIVE)
    else $error("emulation active during restore");
  done_hold_a: assert property (
    rd_ok && PADDR == `EEC_OFS_STAT && PRDATA[7] |-> !CPU_HOLD)
    else $error("done seen while cpu held");
  emul_view_a: assert property (
    rd_ok && PADDR == `EEC_OFS_PART |->
    PRDATA[15] == EMUL_ACTIVE || PRDATA[15] == $past(EMUL_ACTIVE))
    else $error("partition view disagrees with emulation state");
  cover property ($rose(EMUL_ACTIVE));
  cover property ($fell(CPU_HOLD));
  cover property (PREADY && PSLVERR);
endmodule
`default_nettype wire

// [tb/eec_host.sv]
/*
 * Host side bus master that issues single transfers.
 * Assumes a slave that ends each access phase with pready.
 */
`default_nettype none
module eec_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [9:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // ----------------------------------------------------------------
  // one transfer, no wait count assumed
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [9:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic e);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    // released data flips so stale values cannot pass for fresh ones
    {psel, penable, pwdata} <= {1'b0, 1'b0, ~d};
  endtask
endmodule
`default_nettype wire

// [tb/test_eec_ctrl.sv]
/*
 * Self-checking bench for the emulated-EEPROM command controller.
 * Assumes eec_ctrl, eec_host and eec_ctrl_chk are compiled first.
 */
`default_nettype none
`include "eec_map.svh"
module test_eec_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SW = 4;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic pwr_resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, cpu_hold, emul_active;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  int errors = 0;
  int n_tests = 0;
  logic [15:0] seed = 16'h004e;
  always #10 core_clk = ~core_clk;
  eec_host u_eec_host (.clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  eec_ctrl #(.SEC_WORDS(SW)) u_eec_ctrl (.CORE_CLK(core_clk),
    .RESETN(resetn), .PWR_RESETN(pwr_resetn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CPU_HOLD(cpu_hold), .EMUL_ACTIVE(emul_active));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // general data flash left over at the minimum record ratio
  function automatic logic [7:0] df_for(input logic [4:0] sec);
    return (sec == 5'h01) ? 8'h80 - 8'h0c : 8'h80 - 8'(sec * 8'h08);
  endfunction
  function automatic logic [31:0] part_view(input logic en,
      input logic [4:0] sec, input logic [7:0] df);
    return {16'h0000, en, 2'h0, sec, df};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_eec_host.xfer(1'b1, a, d, 4'hf, r, e);
  endtask
  task automatic rc(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    u_eec_host.xfer(1'b0, a, 32'h0, 4'h0, r, e);
    chk(r, exp);
  endtask
  // poke writes the index while the command is still running
  task automatic cmd(input logic [7:0] c, input logic [15:0] w1,
      input logic [15:0] w2, input logic poke, output logic [31:0] st);
    logic e;
    wr(`EEC_OFS_STAT, 32'h30);
    wr(`EEC_OFS_INDEX, 32'h0);
    wr(`EEC_OFS_WORD, {16'h0, c, 8'h00});
    wr(`EEC_OFS_INDEX, 32'h1);
    wr(`EEC_OFS_WORD, {16'h0, w1});
    wr(`EEC_OFS_INDEX, 32'h2);
    wr(`EEC_OFS_WORD, {16'h0, w2});
    wr(`EEC_OFS_STAT, 32'h80);
    if (poke) wr(`EEC_OFS_INDEX, 32'h3);
    do u_eec_host.xfer(1'b0, `EEC_OFS_STAT, 32'h0, 4'h0, st, e);
    while (st[7] !== 1'b1);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    logic [15:0] v;
    logic [15:0] exp [8];
    logic [7:0] div [3] = '{8'h01, 8'h07, 8'h18};
    int n;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    pwr_resetn <= 1'b1;
    rc(`EEC_OFS_STAT, 32'h80);
    rc(`EEC_OFS_PART, part_view(1'b0, 5'h00, df_for(5'h00)));
    chk({31'h0, cpu_hold}, 32'h0);
    wr(`EEC_OFS_STAT, 32'h80);
    rc(`EEC_OFS_STAT, 32'ha0);
    wr(`EEC_OFS_STAT, 32'h00);
    rc(`EEC_OFS_STAT, 32'ha0);
    wr(`EEC_OFS_STAT, 32'h20);
    rc(`EEC_OFS_STAT, 32'h80);
    foreach (div[i]) begin
      wr(`EEC_OFS_CLKDIV, {24'h0, div[i]});
      rc(`EEC_OFS_CLKDIV, {24'h0, div[i] | 8'h80});
    end
    u_eec_host.xfer(1'b0, 10'h018, 32'h0, 4'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(`EEC_OFS_INDEX, 32'h0);
    u_eec_host.xfer(1'b1, `EEC_OFS_WORD, 32'h5a11, 4'h2, r, e);
    u_eec_host.xfer(1'b1, `EEC_OFS_WORD, 32'h22c3, 4'h1, r, e);
    rc(`EEC_OFS_WORD, 32'h5ac3);
    for (int i = 1; i <= 7; i++) begin
      seed = lfsr(seed);
      exp[i] = seed;
      wr(`EEC_OFS_INDEX, 32'(i));
      wr(`EEC_OFS_WORD, {16'h0, seed});
    end
    for (int i = 1; i <= 7; i++) begin
      wr(`EEC_OFS_INDEX, 32'(i));
      rc(`EEC_OFS_WORD, {16'h0, exp[i]});
    end
    cmd(8'h20, 16'd120, 16'd1, 1'b0, r);
    chk(r, 32'ha0);
    cmd(8'h20, 16'd0, 16'd17, 1'b0, r);
    chk(r, 32'ha0);
    cmd(8'h7e, 16'h0, 16'h0, 1'b0, r);
    chk(r, 32'ha0);
    seed = lfsr(seed);
    v = seed;
    wr(10'h114, {16'h0, v});
    cmd(8'h20, {8'h00, df_for(5'h01)}, 16'h0001, 1'b1, r);
    chk(r, 32'h80);
    rc(`EEC_OFS_INDEX, 32'h2);
    rc(`EEC_OFS_ERRSTAT, 32'h1);
    wr(`EEC_OFS_ERRSTAT, 32'h1);
    rc(`EEC_OFS_ERRSTAT, 32'h0);
    for (int i = 0; i < SW; i++) rc(10'h100 + 10'(4 * i), 32'hffff);
    rc(10'h114, {16'h0, v});
    rc(`EEC_OFS_PART, part_view(1'b0, 5'h01, df_for(5'h01)));
    cmd(8'h15, 16'h0, 16'h0, 1'b0, r);
    wr(`EEC_OFS_INDEX, 32'h1);
    rc(`EEC_OFS_WORD, 32'h74);
    wr(`EEC_OFS_INDEX, 32'h2);
    rc(`EEC_OFS_WORD, 32'h1);
    cmd(8'h13, 16'h0, 16'h0, 1'b0, r);
    chk({31'h0, emul_active}, 32'h1);
    rc(`EEC_OFS_PART, part_view(1'b1, 5'h01, df_for(5'h01)));
    seed = lfsr(seed);
    v = seed;
    wr(10'h108, {16'h0, v});
    rc(10'h108, {16'h0, v});
    // the backup scan has no visible completion, so give it time
    repeat (20) @(posedge core_clk);
    cmd(8'h20, 16'd116, 16'd1, 1'b0, r);
    chk(r, 32'h90);
    cmd(8'h14, 16'h0, 16'h0, 1'b0, r);
    chk({31'h0, emul_active}, 32'h0);
    // no record is made now, so only the restore can bring v back
    wr(10'h108, {16'h0, ~v});
    resetn <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({31'h0, cpu_hold}, 32'h1);
    resetn <= 1'b1;
    n = 0;
    while (cpu_hold !== 1'b0 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, cpu_hold}, 32'h0);
    rc(10'h108, {16'h0, v});
    rc(`EEC_OFS_PART, part_view(1'b0, 5'h01, df_for(5'h01)));
    wr(`EEC_OFS_CLKDIV, 32'h18);
    cmd(8'h20, {8'h00, df_for(5'h10)}, 16'h0010, 1'b0, r);
    chk(r, 32'h80);
    rc(10'h1fc, 32'hffff);
    rc(`EEC_OFS_PART, part_view(1'b0, 5'h10, df_for(5'h10)));
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    give_verdict;
  end
endmodule
bind eec_ctrl eec_ctrl_chk #(.SEC_WORDS(SEC_WORDS)) u_chk (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .PWR_RESETN(PWR_RESETN),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CPU_HOLD(CPU_HOLD), .EMUL_ACTIVE(EMUL_ACTIVE));
`default_nettype wire
